/* File: include/dbp_pkg.sv */
/*
 * Package for the dual bidirectional port block: register indices,
 * field positions and reset values.
 * Assumes a plain register port with 4-bit address and 8-bit data.
 */
package dbp_pkg;
    localparam int          DBP_DW               = 8;
    localparam int          DBP_AW               = 4;
    localparam logic [3:0]  DBP_UPPER_PIN_ADDR   = 4'h0;
    localparam logic [3:0]  DBP_UPPER_LATCH_ADDR = 4'h1;
    localparam logic [3:0]  DBP_UPPER_DIR_ADDR   = 4'h2;
    localparam logic [3:0]  DBP_CTRL_PIN_ADDR    = 4'h3;
    localparam logic [3:0]  DBP_CTRL_LATCH_ADDR  = 4'h4;
    localparam logic [3:0]  DBP_CTRL_DIR_ADDR    = 4'h5;
    localparam logic [3:0]  DBP_MISC_ADDR        = 4'h6;
    localparam logic [3:0]  DBP_MEMCTL_ADDR      = 4'h7;
    localparam int          DBP_PULLUP_BIT       = 5;
    localparam int          DBP_BUS_DIS_BIT      = 7;
    localparam int          DBP_ADDR_PINS        = 4;
    localparam logic [7:0]  DBP_DIR_RST          = 8'hFF;
    localparam logic [7:0]  DBP_LATCH_RST        = 8'h00;
    localparam logic [7:0]  DBP_MISC_RST         = 8'h00;
    localparam logic [7:0]  DBP_MEMCTL_RST       = 8'h80;
endpackage : dbp_pkg

/* File: hw/dbp_top.sv */
/*
 * Two 8-bit bidirectional ports with external memory bus override.
 * Assumes pins resolved outside from out/oe/pullup; one clock, ref_clk.
 */
// The implementer's own choices: strobed register access and the register addresses.
// Function
// RL1 - Upper port: eight pins, latch, direction
// RL2 - Each pin has own direction bit
// RL3 - Direction 1 input, 0 output
// RL4 - Bus enabled: upper pins 0-3 carry address
// RL5 - Address outputs beat latch data
// RL6 - Override leaves stored direction unchanged
// RL7 - Control port: eight pins, latch, direction
// RL8 - Control pins are inputs after reset
// RL9 - Control pins have weak pull-ups
// RL10 - Clearing shared bit disables control pull-ups
// RL11 - Output pins have pull-up off
// RL12 - Pull-ups disabled after reset
// RL13 - Bus disable cleared: control pins are bus
// RL14 - Bus ownership overrides control direction
// RL15 - Control pins carry bus strobes in order
// RL16 - Pin register reads pins, write loads latch
`timescale 1ns/10ps
module dbp_top
    import dbp_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                srst,
    input  wire logic [DBP_AW-1:0]   reg_addr,
    input  wire logic [DBP_DW-1:0]   reg_wdata,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    output logic      [DBP_DW-1:0]   reg_rdata,
    input  wire logic [3:0]          mem_addr_hi,
    input  wire logic                mem_ale,
    input  wire logic                mem_oe_n,
    input  wire logic                write_low_strobe,
    input  wire logic                write_high_strobe,
    input  wire logic                byte_address_zero,
    input  wire logic                mem_ce_n,
    input  wire logic                mem_lb_n,
    input  wire logic                mem_ub_n,
    output logic                     mem_bus_enabled,
    input  wire logic [7:0]          upper_pin_in,
    output logic      [7:0]          upper_pin_out,
    output logic      [7:0]          upper_pin_oe,
    input  wire logic [7:0]          ctrl_pin_in,
    output logic      [7:0]          ctrl_pin_out,
    output logic      [7:0]          ctrl_pin_oe,
    output logic      [7:0]          ctrl_pin_pullup
);
    logic [7:0] upper_latch_reg;
    logic [7:0] upper_dir_reg;
    logic [7:0] ctrl_latch_reg;
    logic [7:0] ctrl_dir_reg;
    logic [7:0] misc_reg;
    logic [7:0] memctl_reg;
    logic [7:0] up_s1_reg, up_s2_reg, up_s3_reg, up_val_reg;
    logic [7:0] cp_s1_reg, cp_s2_reg, cp_s3_reg, cp_val_reg;
    logic [7:0] ctrl_bus_val;
    logic [7:0] up_out_next, up_oe_next;
    logic [7:0] cp_out_next, cp_oe_next, cp_pu_next;
    logic       bus_on;
    logic [7:0] rdata_next;

    // Bus active while its disable bit is clear
    assign bus_on = ~memctl_reg[DBP_BUS_DIS_BIT]; // RL13

    // Control port strobes in pin order 0..7
    assign ctrl_bus_val = {mem_ub_n, mem_lb_n, mem_ce_n, byte_address_zero,
                           write_high_strobe, write_low_strobe, mem_oe_n,
                           mem_ale}; // RL15

    // Software registers
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            upper_latch_reg <= DBP_LATCH_RST;
            upper_dir_reg   <= DBP_DIR_RST;
            ctrl_latch_reg  <= DBP_LATCH_RST;
            ctrl_dir_reg    <= DBP_DIR_RST; // RL8
            misc_reg        <= DBP_MISC_RST; // RL12
            memctl_reg      <= DBP_MEMCTL_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                DBP_UPPER_PIN_ADDR,
                DBP_UPPER_LATCH_ADDR: upper_latch_reg <= reg_wdata; // RL16
                DBP_UPPER_DIR_ADDR:   upper_dir_reg   <= reg_wdata; // RL1
                DBP_CTRL_PIN_ADDR,
                DBP_CTRL_LATCH_ADDR:  ctrl_latch_reg  <= reg_wdata; // RL16
                DBP_CTRL_DIR_ADDR:    ctrl_dir_reg    <= reg_wdata; // RL7
                DBP_MISC_ADDR:        misc_reg        <= reg_wdata;
                DBP_MEMCTL_ADDR:      memctl_reg      <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Pin inputs: three stages, change taken when stages 2 and 3 agree
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            up_s1_reg  <= 8'h00;
            up_s2_reg  <= 8'h00;
            up_s3_reg  <= 8'h00;
            up_val_reg <= 8'h00;
            cp_s1_reg  <= 8'h00;
            cp_s2_reg  <= 8'h00;
            cp_s3_reg  <= 8'h00;
            cp_val_reg <= 8'h00;
        end else begin
            up_s1_reg <= upper_pin_in;
            up_s2_reg <= up_s1_reg;
            up_s3_reg <= up_s2_reg;
            cp_s1_reg <= ctrl_pin_in;
            cp_s2_reg <= cp_s1_reg;
            cp_s3_reg <= cp_s2_reg;
            for (int i = 0; i < 8; i++) begin
                if (up_s2_reg[i] == up_s3_reg[i])
                    up_val_reg[i] <= up_s3_reg[i];
                if (cp_s2_reg[i] == cp_s3_reg[i])
                    cp_val_reg[i] <= cp_s3_reg[i];
            end
        end
    end

    // Per-pin drive selection
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pin
            if (g < DBP_ADDR_PINS) begin : g_addr
                assign up_out_next[g] = bus_on ? mem_addr_hi[g]
                                               : upper_latch_reg[g]; // RL4 RL5
                assign up_oe_next[g]  = bus_on | ~upper_dir_reg[g]; // RL6
            end else begin : g_plain
                assign up_out_next[g] = upper_latch_reg[g];
                assign up_oe_next[g]  = ~upper_dir_reg[g]; // RL2 RL3
            end
            assign cp_out_next[g] = bus_on ? ctrl_bus_val[g]
                                           : ctrl_latch_reg[g];
            assign cp_oe_next[g]  = bus_on | ~ctrl_dir_reg[g]; // RL14
            assign cp_pu_next[g]  = misc_reg[DBP_PULLUP_BIT]
                                    & ~cp_oe_next[g]; // RL9 RL10 RL11
        end
    endgenerate

    always_comb begin
        rdata_next = 8'h00;
        unique case (reg_addr)
            DBP_UPPER_PIN_ADDR:   rdata_next = up_val_reg; // RL16
            DBP_UPPER_LATCH_ADDR: rdata_next = upper_latch_reg;
            DBP_UPPER_DIR_ADDR:   rdata_next = upper_dir_reg;
            DBP_CTRL_PIN_ADDR:    rdata_next = cp_val_reg;
            DBP_CTRL_LATCH_ADDR:  rdata_next = ctrl_latch_reg;
            DBP_CTRL_DIR_ADDR:    rdata_next = ctrl_dir_reg;
            DBP_MISC_ADDR:        rdata_next = misc_reg;
            DBP_MEMCTL_ADDR:      rdata_next = memctl_reg;
            default:              rdata_next = 8'h00;
        endcase
    end

    // Registered outputs
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata       <= 8'h00;
            upper_pin_out   <= 8'h00;
            upper_pin_oe    <= 8'h00;
            ctrl_pin_out    <= 8'h00;
            ctrl_pin_oe     <= 8'h00;
            ctrl_pin_pullup <= 8'h00;
            mem_bus_enabled <= 1'b0;
        end else begin
            reg_rdata       <= reg_rd ? rdata_next : 8'h00;
            upper_pin_out   <= up_out_next;
            upper_pin_oe    <= up_oe_next;
            ctrl_pin_out    <= cp_out_next;
            ctrl_pin_oe     <= cp_oe_next;
            ctrl_pin_pullup <= cp_pu_next;
            mem_bus_enabled <= bus_on;
        end
    end

    property p_addr_prio;
        @(posedge ref_clk) disable iff (srst)
        bus_on |=> (upper_pin_out[3:0] == $past(mem_addr_hi))
                   && (upper_pin_oe[3:0] == 4'hF);
    endproperty
    a_addr_prio: assert property (p_addr_prio) // RL4
        else $error("address pins not driven by bus");

    property p_dir_kept;
        @(posedge ref_clk) disable iff (srst)
        (bus_on && !reg_wr) |=> $stable(upper_dir_reg);
    endproperty
    a_dir_kept: assert property (p_dir_kept) // RL6
        else $error("direction changed by override");

    property p_dir_plain;
        @(posedge ref_clk) disable iff (srst)
        1'b1 |=> upper_pin_oe[7:4] == ~$past(upper_dir_reg[7:4]);
    endproperty
    a_dir_plain: assert property (p_dir_plain) // RL3
        else $error("upper direction wrong");

    property p_latch_drive;
        @(posedge ref_clk) disable iff (srst)
        !bus_on |=> ctrl_pin_out == $past(ctrl_latch_reg);
    endproperty
    a_latch_drive: assert property (p_latch_drive) // RL16
        else $error("control latch not driven");

    property p_ctrl_own;
        @(posedge ref_clk) disable iff (srst)
        bus_on |=> ctrl_pin_oe == 8'hFF
                   && ctrl_pin_out == $past(ctrl_bus_val);
    endproperty
    a_ctrl_own: assert property (p_ctrl_own) // RL14
        else $error("control port not owned by bus");

    property p_pu_out_off;
        @(posedge ref_clk) disable iff (srst)
        (ctrl_pin_oe & ctrl_pin_pullup) == 8'h00;
    endproperty
    a_pu_out_off: assert property (p_pu_out_off) // RL11
        else $error("pull-up on output pin");

    property p_pu_dis;
        @(posedge ref_clk) disable iff (srst)
        !misc_reg[DBP_PULLUP_BIT] |=> ctrl_pin_pullup == 8'h00;
    endproperty
    a_pu_dis: assert property (p_pu_dis) // RL10
        else $error("pull-up on while disabled");

    property p_reset_state;
        @(posedge ref_clk)
        srst |=> ctrl_dir_reg == 8'hFF && misc_reg[DBP_PULLUP_BIT] == 1'b0;
    endproperty
    a_reset_state: assert property (p_reset_state) // RL8
        else $error("control port reset state wrong");

    property p_rd_pins;
        @(posedge ref_clk) disable iff (srst)
        (reg_rd && reg_addr == DBP_CTRL_PIN_ADDR) |=>
            reg_rdata == $past(cp_val_reg);
    endproperty
    a_rd_pins: assert property (p_rd_pins) // RL16
        else $error("pin read wrong");

    property p_bus_flag;
        @(posedge ref_clk) disable iff (srst)
        1'b1 |=> mem_bus_enabled == $past(bus_on);
    endproperty
    a_bus_flag: assert property (p_bus_flag) // RL13
        else $error("bus enable flag wrong");

    property p_ctrl_dir_free;
        @(posedge ref_clk) disable iff (srst)
        !bus_on |=> ctrl_pin_oe == ~$past(ctrl_dir_reg);
    endproperty
    a_ctrl_dir_free: assert property (p_ctrl_dir_free) // RL2
        else $error("control direction wrong");

    property p_up_high_out;
        @(posedge ref_clk) disable iff (srst)
        1'b1 |=> upper_pin_out[7:4] == $past(upper_latch_reg[7:4]);
    endproperty
    a_up_high_out: assert property (p_up_high_out) // RL16
        else $error("upper latch not driven");

    property p_addr_free;
        @(posedge ref_clk) disable iff (srst)
        !bus_on |=> upper_pin_out[3:0] == $past(upper_latch_reg[3:0])
                    && upper_pin_oe[3:0] == ~$past(upper_dir_reg[3:0]);
    endproperty
    a_addr_free: assert property (p_addr_free) // RL4
        else $error("address pins held while bus off");

    property p_pu_on;
        @(posedge ref_clk) disable iff (srst)
        (misc_reg[DBP_PULLUP_BIT] && !bus_on)
            |=> ctrl_pin_pullup == $past(ctrl_dir_reg);
    endproperty
    a_pu_on: assert property (p_pu_on) // RL9
        else $error("pull-up missing on input pin");

    property p_reset_pins;
        @(posedge ref_clk)
        srst |=> ctrl_pin_oe == 8'h00 && ctrl_pin_pullup == 8'h00;
    endproperty
    a_reset_pins: assert property (p_reset_pins) // RL12
        else $error("control pins not released by reset");

    property p_rd_idle;
        @(posedge ref_clk) disable iff (srst)
        !reg_rd |=> reg_rdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) // RL16
        else $error("read data outside read cycle");

    property p_rd_dir;
        @(posedge ref_clk) disable iff (srst)
        (reg_rd && reg_addr == DBP_UPPER_DIR_ADDR) |=>
            reg_rdata == $past(upper_dir_reg);
    endproperty
    a_rd_dir: assert property (p_rd_dir) // RL6
        else $error("stored direction read wrong");

    // Register write, then one cycle in which the new value feeds the pins
    sequence s_ctrl_dir_wr;
        (reg_wr && reg_addr == DBP_CTRL_DIR_ADDR) ##1 !bus_on;
    endsequence

    sequence s_up_latch_wr;
        (reg_wr && reg_addr == DBP_UPPER_PIN_ADDR) ##1 !bus_on;
    endsequence

    sequence s_ctrl_pin_wr;
        (reg_wr && reg_addr == DBP_CTRL_PIN_ADDR) ##1 !bus_on;
    endsequence

    sequence s_bus_grab;
        (reg_wr && reg_addr == DBP_MEMCTL_ADDR
            && !reg_wdata[DBP_BUS_DIS_BIT]) ##1 1'b1;
    endsequence

    sequence s_bus_drop;
        (reg_wr && reg_addr == DBP_MEMCTL_ADDR
            && reg_wdata[DBP_BUS_DIS_BIT]) ##1 1'b1;
    endsequence

    property p_ctrl_dir_wr;
        @(posedge ref_clk) disable iff (srst)
        s_ctrl_dir_wr |=> ctrl_pin_oe == ~$past(reg_wdata, 2);
    endproperty
    a_ctrl_dir_wr: assert property (p_ctrl_dir_wr) // RL7
        else $error("control direction write not applied");

    property p_up_latch_wr;
        @(posedge ref_clk) disable iff (srst)
        s_up_latch_wr |=> upper_pin_out == $past(reg_wdata, 2);
    endproperty
    a_up_latch_wr: assert property (p_up_latch_wr) // RL16
        else $error("upper pin write not driven");

    property p_ctrl_pin_wr;
        @(posedge ref_clk) disable iff (srst)
        s_ctrl_pin_wr |=> ctrl_pin_out == $past(reg_wdata, 2);
    endproperty
    a_ctrl_pin_wr: assert property (p_ctrl_pin_wr) // RL16
        else $error("control pin write not driven");

    property p_bus_grab;
        @(posedge ref_clk) disable iff (srst)
        s_bus_grab |=> ctrl_pin_oe == 8'hFF && upper_pin_oe[3:0] == 4'hF;
    endproperty
    a_bus_grab: assert property (p_bus_grab) // RL14
        else $error("bus enable did not take the pins");

    property p_bus_drop;
        @(posedge ref_clk) disable iff (srst)
        s_bus_drop |=> ctrl_pin_oe == ~$past(ctrl_dir_reg)
                       && !mem_bus_enabled;
    endproperty
    a_bus_drop: assert property (p_bus_drop) // RL13
        else $error("bus disable did not free the pins");
endmodule : dbp_top

/* File: tb/dbp_far_model.sv */
/* Far-side model of the two pin groups.
   Assumes the bench sets the levels that outside parts put on the pins. */
`timescale 1ns/10ps
module dbp_far_model (
    input  wire logic [7:0] ext_up,
    input  wire logic [7:0] ext_ct,
    input  wire logic [7:0] upper_pin_out,
    input  wire logic [7:0] upper_pin_oe,
    input  wire logic [7:0] ctrl_pin_out,
    input  wire logic [7:0] ctrl_pin_oe,
    output logic      [7:0] upper_pin_in,
    output logic      [7:0] ctrl_pin_in
);
    // Driven pins show the block's value, released pins the outside level
    assign upper_pin_in = (upper_pin_oe & upper_pin_out)
                        | (~upper_pin_oe & ext_up);
    assign ctrl_pin_in  = (ctrl_pin_oe & ctrl_pin_out) | (~ctrl_pin_oe & ext_ct);
endmodule : dbp_far_model

/* File: tb/dbp_top_tb_top.sv */
/* Self-checking bench for dbp_top.
   Assumes dbp_far_model resolves the pins; bench supplies bus levels. */
`timescale 1ns/10ps
module dbp_top_tb_top;
    import dbp_pkg::*;
    logic        ref_clk = 1'b0;
    logic        srst = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  ext_up = 8'h00;
    logic [7:0]  ext_ct = 8'h00;
    logic [11:0] mem_word = 12'h000;
    logic [7:0]  reg_rdata, up_out, up_oe, up_in, ct_out, ct_oe, ct_in, ct_pu;
    logic        bus_en;
    logic        rd_seen = 1'b0;
    logic [7:0]  exp_q[$];
    logic [7:0]  lat, dv, e;
    logic [31:0] seed = 32'h55CB;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;

    dbp_top i_dbp_top (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .mem_addr_hi(mem_word[3:0]),
        .mem_ale(mem_word[4]), .mem_oe_n(mem_word[5]),
        .write_low_strobe(mem_word[6]), .write_high_strobe(mem_word[7]),
        .byte_address_zero(mem_word[8]), .mem_ce_n(mem_word[9]),
        .mem_lb_n(mem_word[10]), .mem_ub_n(mem_word[11]),
        .mem_bus_enabled(bus_en), .upper_pin_in(up_in),
        .upper_pin_out(up_out), .upper_pin_oe(up_oe), .ctrl_pin_in(ct_in),
        .ctrl_pin_out(ct_out), .ctrl_pin_oe(ct_oe), .ctrl_pin_pullup(ct_pu));
    dbp_far_model i_dbp_far_model (.ext_up(ext_up), .ext_ct(ext_ct),
        .upper_pin_out(up_out), .upper_pin_oe(up_oe),
        .ctrl_pin_out(ct_out), .ctrl_pin_oe(ct_oe),
        .upper_pin_in(up_in), .ctrl_pin_in(ct_in));

    always #20 ref_clk = ~ref_clk;

    function automatic logic [7:0] rnd();
        repeat (8)
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    // Strobe stays up so back-to-back accesses assign it once per edge
    task automatic acc(input logic w, input logic [3:0] a,
                       input logic [7:0] d);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= w ? d : 8'h00;
        if (!w) exp_q.push_back(d);
        @(posedge ref_clk);
    endtask : acc

    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle

    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // Read data stand only in the cycle after the read strobe
    always @(posedge ref_clk) begin
        if (rd_seen) chk(reg_rdata, exp_q.pop_front());
        rd_seen <= reg_rd && !srst;
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            stop_test();
        end
    end

    initial begin
        repeat (5) @(posedge ref_clk);
        srst <= 1'b0;
        ext_up <= rnd();
        ext_ct <= rnd();
        idle(6);
        chk(up_oe | ct_oe | ct_pu, 8'h00);
        acc(1'b1, 4'h9, 8'hFF);
        for (int a = 0; a < 10; a++) begin
            case (a)
                0: e = ext_up;
                2, 5: e = DBP_DIR_RST;
                3: e = ext_ct;
                7: e = DBP_MEMCTL_RST;
                default: e = 8'h00;
            endcase
            acc(1'b0, a[3:0], e);
        end
        lat = rnd();
        dv = rnd();
        acc(1'b1, DBP_UPPER_PIN_ADDR, lat);
        acc(1'b1, DBP_UPPER_DIR_ADDR, 8'hCF);
        acc(1'b1, DBP_CTRL_LATCH_ADDR, dv);
        acc(1'b1, DBP_CTRL_DIR_ADDR, 8'h0F);
        acc(1'b1, DBP_MISC_ADDR, 8'h20);
        idle(2);
        chk(up_oe, 8'h30);
        chk(up_out & 8'h30, lat & 8'h30);
        chk(ct_oe, 8'hF0);
        chk(ct_out & 8'hF0, dv & 8'hF0);
        chk(ct_pu, 8'h0F);
        acc(1'b0, DBP_UPPER_LATCH_ADDR, lat);
        acc(1'b1, DBP_MISC_ADDR, 8'h00);
        idle(6);
        chk(ct_pu, 8'h00);
        acc(1'b0, DBP_UPPER_PIN_ADDR, (ext_up & 8'hCF) | (lat & 8'h30));
        acc(1'b0, DBP_CTRL_PIN_ADDR, (ext_ct & 8'h0F) | (dv & 8'hF0));
        acc(1'b1, DBP_MISC_ADDR, 8'h20);
        mem_word <= {rnd(), dv[3:0]};
        acc(1'b1, DBP_MEMCTL_ADDR, 8'h00);
        idle(2);
        chk({7'h00, bus_en}, 8'h01);
        chk(up_oe, 8'h3F);
        chk(up_out & 8'h3F, {2'b00, lat[5:4], mem_word[3:0]});
        chk(ct_oe, 8'hFF);
        chk(ct_out, mem_word[11:4]);
        chk(ct_pu, 8'h00);
        acc(1'b0, DBP_UPPER_DIR_ADDR, 8'hCF);
        acc(1'b0, DBP_CTRL_DIR_ADDR, 8'h0F);
        acc(1'b0, DBP_MISC_ADDR, 8'h20);
        acc(1'b1, DBP_MEMCTL_ADDR, DBP_MEMCTL_RST);
        idle(2);
        chk({7'h00, bus_en}, 8'h00);
        chk(ct_oe, 8'hF0);
        chk(ct_pu, 8'h0F);
        srst <= 1'b1;
        idle(3);
        chk(up_oe | ct_oe | ct_pu | {7'h00, bus_en}, 8'h00);
        srst <= 1'b0;
        idle(6);
        acc(1'b0, DBP_MEMCTL_ADDR, DBP_MEMCTL_RST);
        acc(1'b0, DBP_CTRL_DIR_ADDR, DBP_DIR_RST);
        acc(1'b1, DBP_CTRL_PIN_ADDR, ~dv);
        acc(1'b1, DBP_UPPER_LATCH_ADDR, ~lat);
        acc(1'b0, DBP_CTRL_LATCH_ADDR, ~dv);
        acc(1'b0, DBP_UPPER_LATCH_ADDR, ~lat);
        idle(3);
        chk(ct_out, ~dv);
        stop_test();
    end
endmodule : dbp_top_tb_top
